// file: hw/fdie_defines.vh
/*
 * Constants of the modulation and dither engine: register offsets,
 * field positions, reset values and shift-register start values.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef FDIE_DEFINES_VH
`define FDIE_DEFINES_VH

// Register offsets (byte addresses on the configuration port)
`define FDIE_OFS_CTRL       12'h40c
`define FDIE_OFS_POINTER    12'h418
`define FDIE_OFS_DATA       12'h41c
`define FDIE_OFS_SEED_RED   12'h430
`define FDIE_OFS_SEED_GREEN 12'h434
`define FDIE_OFS_SEED_BLUE  12'h438
`define FDIE_OFS_STATUS     12'h43c

// Control register fields
`define FDIE_CTRL_DITHER_EN     0
`define FDIE_CTRL_DBITS_LO      1
`define FDIE_CTRL_DBITS_HI      3
`define FDIE_CTRL_LEVELS_LO     4
`define FDIE_CTRL_LEVELS_HI     6
`define FDIE_CTRL_RAM_SEL       12
`define FDIE_CTRL_RESET         13'h0000

// Pointer register fields
`define FDIE_PTR_INDEX_LO       0
`define FDIE_PTR_INDEX_HI       5
`define FDIE_PTR_SEL_LO         8
`define FDIE_PTR_SEL_HI         9
`define FDIE_PTR_RESET          8'h00

// Colour table select codes
`define FDIE_SEL_ALL            2'h0
`define FDIE_SEL_RED            2'h1
`define FDIE_SEL_GREEN          2'h2
`define FDIE_SEL_BLUE           2'h3

// Shift-register start values and seed reset value
`define FDIE_GLOBAL_INIT        15'h0001
`define FDIE_LOCAL_INIT         9'h001
`define FDIE_SEED_RESET         15'h0001

// Data path
`define FDIE_FIFO_DEPTH         32
`define FDIE_FIFO_AW            5
`define FDIE_FIFO_WIDTH         20
`define FDIE_LEVELS_MAX_CODE    3'h4

`endif

// file: hw/fdie_fifo.v
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; DEPTH is a power of two equal to 2**AW.
 */
`timescale 1ns/10ps
module fdie_fifo #(
	parameter WIDTH = 20,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             clock_i,
	input  wire             rst_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	localparam [AW:0] FULL_CNT = {1'b1, {AW{1'b0}}};

	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_ff;
	reg [AW-1:0]    rd_ptr_ff;
	reg [AW:0]      cnt_ff;
	wire            push;
	wire            pop;

	assign in_ready_o  = (cnt_ff != FULL_CNT);
	assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_ready_i & out_valid_o;
	assign out_data_o  = mem_ff[rd_ptr_ff];

	always @(posedge clock_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data_i;
		end
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			cnt_ff    <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			if (push & ~pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop & ~push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule // fdie_fifo

// file: hw/fdie_table_mem.v
/*
 * One 32 x 64 modulation table: 32-bit half writes and reads from the
 * configuration side, 64-bit word reads for pixels; reads registered.
 * Assumes one clock; pointer bit 0 picks the half, bits 5:1 the row.
 */
`timescale 1ns/10ps
module fdie_table_mem (
	input  wire        clock_i,
	input  wire        wr_en_i,
	input  wire [5:0]  cfg_ptr_i,
	input  wire [31:0] wr_data_i,
	input  wire        cfg_rd_en_i,
	output reg  [31:0] cfg_rdata_o,
	input  wire        pix_rd_en_i,
	input  wire [4:0]  pix_addr_i,
	output reg  [63:0] pix_word_o
);
	reg [31:0] lo_ff [0:31];
	reg [31:0] hi_ff [0:31];

	always @(posedge clock_i) begin
		if (wr_en_i & ~cfg_ptr_i[0])
			lo_ff[cfg_ptr_i[5:1]] <= wr_data_i;
		if (wr_en_i & cfg_ptr_i[0])
			hi_ff[cfg_ptr_i[5:1]] <= wr_data_i;
		if (cfg_rd_en_i)
			cfg_rdata_o <= cfg_ptr_i[0] ? hi_ff[cfg_ptr_i[5:1]] : lo_ff[cfg_ptr_i[5:1]];
		if (pix_rd_en_i)
			pix_word_o <= {hi_ff[pix_addr_i], lo_ff[pix_addr_i]};
	end
endmodule // fdie_table_mem

// file: hw/fdie_top.v
/*
 * Grey-scale engine: spatial dither then frame rate modulation per
 * colour, with three programmable 32 x 64 modulation tables.
 * Assumes pixel stream and configuration port share clock_i; the
 * writable dither pattern memory is outside and answers pat_word_i
 * combinationally for the row on pat_addr_o.
 */
//
// Contract
// - Global 15-bit shift register steps every pixel
// - Local 9-bit shift register steps every line
// - Both shift registers restart each frame
// - Index adds low 6 bits of both
// - Frame counter rotates start over 64 frames
// - Per-colour seeded 15-bit shift register
// - Three 32 x 64 tables, loaded by software
// - Select 00 reads red, writes all
// - Word pointer auto-increments on data access
// - Even pointer low half, odd high half
// - Data register accesses pointed half
// - Pattern one decrements pixel one level
// - All-ones dither value passes unchanged
// - Two-bit case decrements three, two, one, none
// - Upper bits modulate, low bits dither
// - Level field picks one to five bits
// - Dither enable bit, modulation always on
// - Dither msb one inverts stored pattern
// - Ram-select zero uses built-in patterns
`timescale 1ns/10ps
`include "fdie_defines.vh"
module fdie_top (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire        pix_valid_i,
	output wire        pix_ready_o,
	input  wire [5:0]  pix_red_i,
	input  wire [5:0]  pix_green_i,
	input  wire [5:0]  pix_blue_i,
	input  wire        line_sync_i,
	input  wire        frame_start_i,
	output wire        panel_valid_o,
	input  wire        panel_ready_i,
	output reg  [2:0]  panel_rgb_o,
	output reg         panel_line_o,
	output reg         panel_frame_o,
	output wire [5:0]  pat_addr_o,
	input  wire [31:0] pat_word_i,
	input  wire [11:0] cfg_addr_i,
	input  wire        cfg_wr_i,
	input  wire        cfg_rd_i,
	input  wire [31:0] cfg_wdata_i,
	output reg  [31:0] cfg_rdata_o,
	output reg         cfg_rvalid_o
);
	// Maximal-length x^15+x^14+1, zero state forced out
	function [14:0] fdie_step15;
		input [14:0] v;
		begin
			if (v == 15'h0000)
				fdie_step15 = 15'h0001;
			else
				fdie_step15 = {v[13:0], v[14] ^ v[13]};
		end
	endfunction

	// Maximal-length x^9+x^5+1
	function [8:0] fdie_step9;
		input [8:0] v;
		begin
			if (v == 9'h000)
				fdie_step9 = 9'h001;
			else
				fdie_step9 = {v[7:0], v[8] ^ v[4]};
		end
	endfunction

	function [14:0] fdie_seed;
		input [14:0] v;
		begin
			fdie_seed = (v == 15'h0000) ? 15'h0001 : v;
		end
	endfunction

	// Table row for one colour after dithering
	function [4:0] fdie_level;
		input [5:0]  pix;
		input [2:0]  lvl_code;
		input [2:0]  dbits_code;
		input        dith_en;
		input        ram_sel;
		input [2:0]  px;
		input [2:0]  py;
		input [31:0] ram_row;
		reg   [2:0]  n;
		reg   [2:0]  d;
		reg   [4:0]  lvl;
		reg   [5:0]  below;
		reg   [4:0]  dval;
		reg   [4:0]  ones;
		reg   [5:0]  thr;
		reg   [4:0]  col;
		reg          pbit;
		reg   [5:0]  wide;
		begin
			n = (lvl_code > `FDIE_LEVELS_MAX_CODE) ? 3'h5 : lvl_code + 3'h1;
			d = (dbits_code > 3'h6 - n) ? 3'h6 - n : dbits_code;
			wide = pix >> (3'h6 - n);
			lvl = wide[4:0];
			below = pix << n;
			wide = below >> (3'h6 - d);
			dval = wide[4:0];
			wide = (6'h01 << d) - 6'h01;
			ones = wide[4:0];
			thr = {px[0] ^ py[0], py[0], px[1] ^ py[1], py[1], px[2] ^ py[2], py[2]};
			thr = thr >> (3'h6 - d);
			col = dval & (ones >> 1);
			if (ram_sel)
				pbit = ram_row[col] ^ dval[d - 3'h1];
			else
				pbit = ({1'b0, dval} < thr);
			if (dith_en && d != 3'h0 && dval != ones && pbit && lvl != 5'h00)
				fdie_level = lvl - 5'h01;
			else
				fdie_level = lvl;
		end
	endfunction

	reg  [12:0] ctrl_ff;
	reg  [1:0]  sel_ff;
	reg  [5:0]  ptr_ff;
	reg  [14:0] seed_ff [0:2];
	reg  [14:0] glob_ff;
	reg  [8:0]  loc_ff;
	reg  [14:0] col_ff [0:2];
	reg  [5:0]  frame_cnt_ff;
	reg         rd_d1_ff;
	reg  [11:0] rd_addr_d1_ff;
	reg  [1:0]  rd_sel_d1_ff;
	reg         a_vld_ff;
	reg         a_line_ff;
	reg         a_frame_ff;
	reg  [17:0] a_pix_ff;
	reg  [2:0]  a_x_ff;
	reg  [2:0]  a_y_ff;
	reg  [17:0] a_idx_ff;
	reg         b_vld_ff;
	reg         b_line_ff;
	reg         b_frame_ff;
	reg  [17:0] b_idx_ff;
	reg         c_vld_ff;
	reg  [14:0] nxt_glob;
	reg  [8:0]  nxt_loc;
	reg  [14:0] cur_col;
	reg  [5:0]  cur_fc;
	reg  [17:0] nxt_idx;
	reg  [14:0] nxt_col [0:2];
	wire        fifo_vld;
	wire [19:0] fifo_data;
	wire        adv_a;
	wire        adv_b;
	wire        adv_c;
	wire        take;
	wire        data_hit;
	wire        data_wr;
	wire        data_rd;
	wire [2:0]  tbl_we;
	wire [31:0] tbl_rdata [0:2];
	wire [63:0] tbl_word [0:2];
	wire [4:0]  row_r;
	wire [4:0]  row_g;
	wire [4:0]  row_b;
	integer     k_cfg;
	integer     k_mix;
	integer     k_seq;

	fdie_fifo #(
		.WIDTH(`FDIE_FIFO_WIDTH),
		.DEPTH(`FDIE_FIFO_DEPTH),
		.AW   (`FDIE_FIFO_AW)
	) u_fifo (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.in_valid_i (pix_valid_i),
		.in_ready_o (pix_ready_o),
		.in_data_i  ({frame_start_i, line_sync_i, pix_red_i, pix_green_i, pix_blue_i}),
		.out_valid_o(fifo_vld),
		.out_ready_i(adv_a),
		.out_data_o (fifo_data)
	);

	// Pipeline advances from the panel end back to the FIFO
	assign adv_c = ~c_vld_ff | panel_ready_i;
	assign adv_b = ~b_vld_ff | adv_c;
	assign adv_a = ~a_vld_ff | adv_b;
	assign take  = fifo_vld & adv_a;
	assign panel_valid_o = c_vld_ff;
	assign pat_addr_o = {a_y_ff, a_x_ff};

	// Configuration port
	assign data_hit = (cfg_addr_i == `FDIE_OFS_DATA);
	assign data_wr  = cfg_wr_i & data_hit;
	assign data_rd  = cfg_rd_i & data_hit;
	assign tbl_we[0] = data_wr & ((sel_ff == `FDIE_SEL_ALL) | (sel_ff == `FDIE_SEL_RED));
	assign tbl_we[1] = data_wr & ((sel_ff == `FDIE_SEL_ALL) | (sel_ff == `FDIE_SEL_GREEN));
	assign tbl_we[2] = data_wr & ((sel_ff == `FDIE_SEL_ALL) | (sel_ff == `FDIE_SEL_BLUE));

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_ff <= `FDIE_CTRL_RESET;
			sel_ff  <= 2'h0;
			ptr_ff  <= 6'h00;
			for (k_cfg = 0; k_cfg < 3; k_cfg = k_cfg + 1)
				seed_ff[k_cfg] <= `FDIE_SEED_RESET;
		end else begin
			if (cfg_wr_i) begin
				if (cfg_addr_i == `FDIE_OFS_CTRL) begin
					ctrl_ff <= cfg_wdata_i[12:0];
				end else if (cfg_addr_i == `FDIE_OFS_POINTER) begin
					sel_ff <= cfg_wdata_i[`FDIE_PTR_SEL_HI:`FDIE_PTR_SEL_LO];
					ptr_ff <= cfg_wdata_i[`FDIE_PTR_INDEX_HI:`FDIE_PTR_INDEX_LO];
				end else if (cfg_addr_i == `FDIE_OFS_SEED_RED) begin
					seed_ff[0] <= cfg_wdata_i[14:0];
				end else if (cfg_addr_i == `FDIE_OFS_SEED_GREEN) begin
					seed_ff[1] <= cfg_wdata_i[14:0];
				end else if (cfg_addr_i == `FDIE_OFS_SEED_BLUE) begin
					seed_ff[2] <= cfg_wdata_i[14:0];
				end
			end
			if (data_wr | data_rd)
				ptr_ff <= ptr_ff + 6'h01;
		end
	end

	// Reads answer two edges after the request
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rd_d1_ff      <= 1'b0;
			rd_addr_d1_ff <= 12'h000;
			rd_sel_d1_ff  <= 2'h0;
			cfg_rdata_o   <= 32'h00000000;
			cfg_rvalid_o  <= 1'b0;
		end else begin
			rd_d1_ff      <= cfg_rd_i;
			rd_addr_d1_ff <= cfg_addr_i;
			rd_sel_d1_ff  <= sel_ff;
			cfg_rvalid_o  <= rd_d1_ff;
			if (rd_d1_ff) begin
				if (rd_addr_d1_ff == `FDIE_OFS_CTRL)
					cfg_rdata_o <= {19'h00000, ctrl_ff};
				else if (rd_addr_d1_ff == `FDIE_OFS_POINTER)
					cfg_rdata_o <= {22'h000000, sel_ff, 2'h0, ptr_ff};
				else if (rd_addr_d1_ff == `FDIE_OFS_DATA)
					cfg_rdata_o <= (rd_sel_d1_ff == `FDIE_SEL_GREEN) ? tbl_rdata[1] :
						(rd_sel_d1_ff == `FDIE_SEL_BLUE) ? tbl_rdata[2] : tbl_rdata[0];
				else if (rd_addr_d1_ff == `FDIE_OFS_SEED_RED)
					cfg_rdata_o <= {17'h00000, seed_ff[0]};
				else if (rd_addr_d1_ff == `FDIE_OFS_SEED_GREEN)
					cfg_rdata_o <= {17'h00000, seed_ff[1]};
				else if (rd_addr_d1_ff == `FDIE_OFS_SEED_BLUE)
					cfg_rdata_o <= {17'h00000, seed_ff[2]};
				else if (rd_addr_d1_ff == `FDIE_OFS_STATUS)
					cfg_rdata_o <= {26'h0000000, frame_cnt_ff};
				else
					cfg_rdata_o <= 32'h00000000;
			end
		end
	end

	// Phase sources for the pixel at the FIFO head
	always @* begin
		nxt_glob = fifo_data[19] ? `FDIE_GLOBAL_INIT : glob_ff;
		nxt_loc  = fifo_data[19] ? `FDIE_LOCAL_INIT : loc_ff;
		if (fifo_data[18] & ~fifo_data[19])
			nxt_loc = fdie_step9(loc_ff);
		cur_fc = fifo_data[19] ? frame_cnt_ff + 6'h01 : frame_cnt_ff;
		nxt_idx = 18'h00000;
		for (k_mix = 0; k_mix < 3; k_mix = k_mix + 1) begin
			cur_col = fifo_data[19] ? fdie_seed(seed_ff[k_mix]) : col_ff[k_mix];
			nxt_col[k_mix] = cur_col;
			nxt_idx[k_mix*6 +: 6] = nxt_glob[5:0] + nxt_loc[5:0] + cur_col[5:0] + cur_fc;
		end
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			glob_ff      <= `FDIE_GLOBAL_INIT;
			loc_ff       <= `FDIE_LOCAL_INIT;
			frame_cnt_ff <= 6'h00;
			for (k_seq = 0; k_seq < 3; k_seq = k_seq + 1)
				col_ff[k_seq] <= `FDIE_SEED_RESET;
			a_vld_ff   <= 1'b0;
			a_line_ff  <= 1'b0;
			a_frame_ff <= 1'b0;
			a_pix_ff   <= 18'h00000;
			a_x_ff     <= 3'h0;
			a_y_ff     <= 3'h0;
			a_idx_ff   <= 18'h00000;
		end else begin
			if (adv_a)
				a_vld_ff <= fifo_vld;
			if (take) begin
				glob_ff <= fdie_step15(nxt_glob);
				loc_ff  <= nxt_loc;
				if (fifo_data[19])
					frame_cnt_ff <= frame_cnt_ff + 6'h01;
				for (k_seq = 0; k_seq < 3; k_seq = k_seq + 1)
					col_ff[k_seq] <= fdie_step15(nxt_col[k_seq]);
				a_line_ff  <= fifo_data[18];
				a_frame_ff <= fifo_data[19];
				a_pix_ff   <= fifo_data[17:0];
				a_idx_ff   <= nxt_idx;
				a_x_ff     <= (fifo_data[18] | fifo_data[19]) ? 3'h0 : a_x_ff + 3'h1;
				if (fifo_data[19])
					a_y_ff <= 3'h0;
				else if (fifo_data[18])
					a_y_ff <= a_y_ff + 3'h1;
			end
		end
	end

	assign row_r = fdie_level(a_pix_ff[17:12], ctrl_ff[6:4], ctrl_ff[3:1], ctrl_ff[0],
		ctrl_ff[12], a_x_ff, a_y_ff, pat_word_i);
	assign row_g = fdie_level(a_pix_ff[11:6], ctrl_ff[6:4], ctrl_ff[3:1], ctrl_ff[0],
		ctrl_ff[12], a_x_ff, a_y_ff, pat_word_i);
	assign row_b = fdie_level(a_pix_ff[5:0], ctrl_ff[6:4], ctrl_ff[3:1], ctrl_ff[0],
		ctrl_ff[12], a_x_ff, a_y_ff, pat_word_i);

	fdie_table_mem u_tbl_red (
		.clock_i    (clock_i),
		.wr_en_i    (tbl_we[0]),
		.cfg_ptr_i  (ptr_ff),
		.wr_data_i  (cfg_wdata_i),
		.cfg_rd_en_i(data_rd),
		.cfg_rdata_o(tbl_rdata[0]),
		.pix_rd_en_i(adv_b),
		.pix_addr_i (row_r),
		.pix_word_o (tbl_word[0])
	);
	fdie_table_mem u_tbl_green (
		.clock_i    (clock_i),
		.wr_en_i    (tbl_we[1]),
		.cfg_ptr_i  (ptr_ff),
		.wr_data_i  (cfg_wdata_i),
		.cfg_rd_en_i(data_rd),
		.cfg_rdata_o(tbl_rdata[1]),
		.pix_rd_en_i(adv_b),
		.pix_addr_i (row_g),
		.pix_word_o (tbl_word[1])
	);
	fdie_table_mem u_tbl_blue (
		.clock_i    (clock_i),
		.wr_en_i    (tbl_we[2]),
		.cfg_ptr_i  (ptr_ff),
		.wr_data_i  (cfg_wdata_i),
		.cfg_rd_en_i(data_rd),
		.cfg_rdata_o(tbl_rdata[2]),
		.pix_rd_en_i(adv_b),
		.pix_addr_i (row_b),
		.pix_word_o (tbl_word[2])
	);

	// Table words arrive with stage B; output bit picked by index
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			b_vld_ff      <= 1'b0;
			b_line_ff     <= 1'b0;
			b_frame_ff    <= 1'b0;
			b_idx_ff      <= 18'h00000;
			c_vld_ff      <= 1'b0;
			panel_rgb_o   <= 3'h0;
			panel_line_o  <= 1'b0;
			panel_frame_o <= 1'b0;
		end else begin
			if (adv_b) begin
				b_vld_ff   <= a_vld_ff;
				b_line_ff  <= a_line_ff;
				b_frame_ff <= a_frame_ff;
				b_idx_ff   <= a_idx_ff;
			end
			if (adv_c) begin
				c_vld_ff      <= b_vld_ff;
				panel_line_o  <= b_line_ff;
				panel_frame_o <= b_frame_ff;
				panel_rgb_o   <= {tbl_word[0][b_idx_ff[5:0]], tbl_word[1][b_idx_ff[11:6]],
					tbl_word[2][b_idx_ff[17:12]]};
			end
		end
	end
endmodule // fdie_top

// file: tb/fdie_chk_assertions.sv
/* Port assertions for fdie_top.
 Bound from tb_top; one clock, reset active high. */
`timescale 1ns/10ps
`include "fdie_defines.vh"
module fdie_chk (
	input logic        clock_i,
	input logic        rst_i,
	input logic        pix_valid_i,
	input logic        pix_ready_o,
	input logic        panel_valid_o,
	input logic        panel_ready_i,
	input logic [2:0]  panel_rgb_o,
	input logic        panel_line_o,
	input logic        panel_frame_o,
	input logic [11:0] cfg_addr_i,
	input logic        cfg_rd_i,
	input logic [31:0] cfg_rdata_o,
	input logic        cfg_rvalid_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	logic [7:0] pend_ff;
	logic       take;
	logic       give;
	logic       mapped;
	assign take = pix_valid_i && pix_ready_o;
	assign give = panel_valid_o && panel_ready_i;
	assign mapped = cfg_addr_i inside {`FDIE_OFS_CTRL, `FDIE_OFS_POINTER, `FDIE_OFS_DATA,
		`FDIE_OFS_SEED_RED, `FDIE_OFS_SEED_GREEN, `FDIE_OFS_SEED_BLUE, `FDIE_OFS_STATUS};
	// Pixels held inside the engine
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			pend_ff <= 8'h00;
		else
			pend_ff <= pend_ff + {7'h00, take} - {7'h00, give};
	end
	a_rd_answer: assert property (cfg_rd_i |-> ##2 cfg_rvalid_o)
		else $error("read not answered after two cycles");
	a_rvalid_cause: assert property (cfg_rvalid_o |-> $past(cfg_rd_i, 2))
		else $error("read answer without read");
	a_rdata_hold: assert property (!cfg_rvalid_o |-> $stable(cfg_rdata_o))
		else $error("read data moved between answers");
	a_unmapped_zero: assert property (cfg_rd_i && !mapped |-> ##2 cfg_rdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_out_hold: assert property (panel_valid_o && !panel_ready_i |=> panel_valid_o
		&& $stable({panel_rgb_o, panel_line_o, panel_frame_o}))
		else $error("stalled pixel changed");
	a_take_to_out: assert property (take |-> ##[1:4] panel_valid_o)
		else $error("taken pixel not presented");
	a_out_cause: assert property (panel_valid_o |-> pend_ff != 8'h00)
		else $error("output pixel without input");
	a_ready_full: assert property (!pix_ready_o |-> pend_ff >= 8'h20)
		else $error("input refused before buffer full");
	c_dec: cover property (give && panel_rgb_o == 3'b010);
	c_full: cover property (!pix_ready_o);
	c_read: cover property (cfg_rvalid_o);
endmodule // fdie_chk

// file: tb/fdie_pix_src.sv
/* Upstream pixel source: offers queued pixels with valid/ready.
 Assumes the bench queues pixels through push(); one clock. */
`timescale 1ns/10ps
module fdie_pix_src (
	input  logic       clock_i,
	input  logic       rst_i,
	input  logic       ready_i,
	output logic       valid_o,
	output logic [5:0] red_o,
	output logic [5:0] green_o,
	output logic [5:0] blue_o,
	output logic       line_o,
	output logic       frame_o
);
	logic [19:0] q[$];
	task push(input logic [19:0] w);
		q.push_back(w);
	endtask
	// Pixel held until taken
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			{frame_o, line_o, red_o, green_o, blue_o} <= 20'h0;
		end else if (!valid_o || ready_i) begin
			if (q.size() != 0) begin
				valid_o <= 1'b1;
				{frame_o, line_o, red_o, green_o, blue_o} <= q.pop_front();
			end else begin
				valid_o <= 1'b0;
				// Idle lines toggle, no stale pixel
				{frame_o, line_o, red_o, green_o, blue_o} <=
					~{frame_o, line_o, red_o, green_o, blue_o};
			end
		end
	end
endmodule // fdie_pix_src

// file: tb/tb_top.sv
/* Bench for fdie_top: register tasks, table load, pixel runs in
 three dither modes, back-pressure. Assumes checker and source. */
`timescale 1ns/10ps
`include "fdie_defines.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("Error %0t: got %h want %h", $time, g, e); end end
module tb_top;
	logic        clock_i;
	logic        rst_i = 1'b1;
	logic        panel_ready_i = 1'b1;
	logic [31:0] pat_word_i = 32'h0;
	logic [11:0] cfg_addr_i = 12'h0;
	logic        cfg_wr_i = 1'b0;
	logic        cfg_rd_i = 1'b0;
	logic [31:0] cfg_wdata_i = 32'h0;
	wire         pix_valid_i, pix_ready_o, line_sync_i, frame_start_i;
	wire  [5:0]  pix_red_i, pix_green_i, pix_blue_i, pat_addr_o;
	wire         panel_valid_o, panel_line_o, panel_frame_o, cfg_rvalid_o;
	wire  [2:0]  panel_rgb_o;
	wire  [31:0] cfg_rdata_o;
	logic [4:0]  got[$];
	integer      err_count = 0;
	integer      n_tests = 0;
	integer      k;
	fdie_top i_fdie_top (.clock_i(clock_i), .rst_i(rst_i), .pix_valid_i(pix_valid_i),
		.pix_ready_o(pix_ready_o), .pix_red_i(pix_red_i), .pix_green_i(pix_green_i),
		.pix_blue_i(pix_blue_i), .line_sync_i(line_sync_i), .frame_start_i(frame_start_i),
		.panel_valid_o(panel_valid_o), .panel_ready_i(panel_ready_i),
		.panel_rgb_o(panel_rgb_o), .panel_line_o(panel_line_o),
		.panel_frame_o(panel_frame_o), .pat_addr_o(pat_addr_o), .pat_word_i(pat_word_i),
		.cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
		.cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o));
	fdie_pix_src i_fdie_pix_src (.clock_i(clock_i), .rst_i(rst_i), .ready_i(pix_ready_o),
		.valid_o(pix_valid_i), .red_o(pix_red_i), .green_o(pix_green_i),
		.blue_o(pix_blue_i), .line_o(line_sync_i), .frame_o(frame_start_i));
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		if (panel_valid_o === 1'b1 && panel_ready_i === 1'b1)
			got.push_back({panel_frame_o, panel_line_o, panel_rgb_o});
	end
	task complete_run;
		$display("Errors %0d, checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task tmo(input logic ok);
		if (!ok) begin
			err_count++;
			$display("Error %0t: wait limit reached", $time);
			complete_run();
		end
	endtask
	task cfg_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		cfg_addr_i <= a;
		cfg_wdata_i <= d;
		cfg_wr_i <= 1'b1;
		@(posedge clock_i);
		cfg_wr_i <= 1'b0;
	endtask
	task cfg_rd(input logic [11:0] a, input logic [31:0] e);
		integer n;
		@(posedge clock_i);
		cfg_addr_i <= a;
		cfg_rd_i <= 1'b1;
		@(posedge clock_i);
		cfg_rd_i <= 1'b0;
		for (n = 0; n < 8 && cfg_rvalid_o !== 1'b1; n++)
			@(posedge clock_i);
		tmo(cfg_rvalid_o === 1'b1);
		`CHK(cfg_rdata_o, e)
	endtask
	task wait_got(input integer n);
		integer c;
		for (c = 0; c < 2000 && got.size() < n; c++)
			@(posedge clock_i);
		tmo(got.size() >= n);
	endtask
	// Odd rows lit in red and blue, even rows lit in green
	task load_tables;
		integer i, s;
		for (s = 0; s < 2; s++) begin
			cfg_wr(`FDIE_OFS_POINTER, s ? 32'h200 : 32'h000);
			for (i = 0; i < 64; i++)
				cfg_wr(`FDIE_OFS_DATA, (i[1] ^ s[0]) ? 32'hffffffff : 32'h0);
		end
	endtask
	// Six pixels: frame start, then line start at the fifth
	task frame_seq(input logic [5:0] dec);
		integer i;
		logic [5:0] p;
		logic [4:0] ex;
		got.delete();
		for (i = 0; i < 6; i++) begin
			p = (i == 2 || i == 3) ? 6'h07 : 6'h06;
			i_fdie_pix_src.push({i == 0, i == 4, p, p, p});
		end
		wait_got(6);
		for (i = 0; i < 6; i++) begin
			ex = {i == 0, i == 4, dec[i] ? 3'b010 : 3'b101};
			`CHK(got[i], ex)
		end
	endtask
	initial begin
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		cfg_rd(`FDIE_OFS_CTRL, 32'h0);
		cfg_rd(`FDIE_OFS_POINTER, 32'h0);
		cfg_rd(`FDIE_OFS_STATUS, 32'h0);
		cfg_rd(12'h400, 32'h0);
		load_tables();
		cfg_wr(`FDIE_OFS_POINTER, 32'h002);
		cfg_rd(`FDIE_OFS_DATA, 32'hffffffff);
		cfg_rd(`FDIE_OFS_DATA, 32'hffffffff);
		cfg_wr(`FDIE_OFS_POINTER, 32'h202);
		cfg_rd(`FDIE_OFS_DATA, 32'h0);
		cfg_wr(`FDIE_OFS_POINTER, 32'h300);
		cfg_rd(`FDIE_OFS_DATA, 32'h0);
		cfg_rd(`FDIE_OFS_DATA, 32'h0);
		cfg_rd(`FDIE_OFS_POINTER, 32'h302);
		cfg_wr(`FDIE_OFS_POINTER, 32'h13f);
		cfg_rd(`FDIE_OFS_DATA, 32'hffffffff);
		cfg_rd(`FDIE_OFS_POINTER, 32'h100);
		cfg_wr(`FDIE_OFS_CTRL, 32'h40);
		cfg_rd(`FDIE_OFS_CTRL, 32'h40);
		frame_seq(6'b000000);
		cfg_wr(`FDIE_OFS_CTRL, 32'h43);
		frame_seq(6'b010010);
		pat_word_i <= 32'hffffffff;
		cfg_wr(`FDIE_OFS_CTRL, 32'h1043);
		frame_seq(6'b110011);
		`CHK(pat_addr_o, 6'h09)
		cfg_rd(`FDIE_OFS_STATUS, 32'h3);
		cfg_wr(`FDIE_OFS_STATUS, 32'h0);
		cfg_rd(`FDIE_OFS_STATUS, 32'h3);
		cfg_wr(`FDIE_OFS_CTRL, 32'h40);
		got.delete();
		panel_ready_i <= 1'b0;
		for (k = 0; k < 40; k++)
			i_fdie_pix_src.push({2'b00, 6'h06, 6'h06, 6'h06});
		for (k = 0; k < 200 && pix_ready_o !== 1'b0; k++)
			@(posedge clock_i);
		tmo(pix_ready_o === 1'b0);
		// Drain with the panel stalling every other pair of cycles
		for (k = 0; k < 400 && got.size() < 40; k++) begin
			@(posedge clock_i);
			panel_ready_i <= k[1];
		end
		tmo(got.size() == 40);
		panel_ready_i <= 1'b1;
		foreach (got[i])
			`CHK(got[i], 5'h05)
		`CHK(pix_ready_o, 1'b1)
		// Red seed steers the first frame pixel onto the one lit bit of row 3
		cfg_wr(`FDIE_OFS_POINTER, 32'h106);
		cfg_wr(`FDIE_OFS_DATA, 32'h0);
		cfg_wr(`FDIE_OFS_DATA, 32'h40);
		cfg_wr(`FDIE_OFS_SEED_RED, 32'h20);
		got.delete();
		for (k = 0; k < 2; k++)
			i_fdie_pix_src.push({2'b10, 6'h06, 6'h06, 6'h06});
		wait_got(2);
		`CHK(got[0], 5'h15)
		`CHK(got[1], 5'h11)
		cfg_rd(`FDIE_OFS_SEED_RED, 32'h20);
		// Two dither bits, msb set: stored pattern read inverted
		cfg_wr(`FDIE_OFS_CTRL, 32'h1035);
		frame_seq(6'b000000);
		complete_run();
	end
endmodule // tb_top
bind fdie_top fdie_chk i_fdie_chk (.clock_i(clock_i), .rst_i(rst_i),
	.pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .panel_valid_o(panel_valid_o),
	.panel_ready_i(panel_ready_i), .panel_rgb_o(panel_rgb_o), .panel_line_o(panel_line_o),
	.panel_frame_o(panel_frame_o), .cfg_addr_i(cfg_addr_i), .cfg_rd_i(cfg_rd_i),
	.cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o));
